// [shared/adc_ctrl_pkg.sv]
// Constants, types and shared decode for the serial converter control logic.
// Assumes one 16-bit serial word per chip-select frame, MSB first.
package adc_ctrl_pkg;

  localparam int unsigned WORD_BITS = 16;
  localparam logic [4:0] CNT_LAST   = 5'h0f;
  localparam logic [4:0] CNT_DONE   = 5'h10;
  localparam logic [4:0] CNT_DATA0  = 5'h03;
  localparam logic [4:0] CNT_DATAN  = 5'h0e;

  // Bit positions inside a written word
  localparam int unsigned POS_WRITE    = 11;
  localparam int unsigned POS_SEQ_EN   = 10;
  localparam int unsigned POS_ADDR_HI  = 8;
  localparam int unsigned POS_ADDR_LO  = 6;
  localparam int unsigned POS_PM_HI    = 5;
  localparam int unsigned POS_PM_LO    = 4;
  localparam int unsigned POS_SEQ_REG  = 3;
  localparam int unsigned POS_RANGE    = 1;
  localparam int unsigned POS_CODING   = 0;

  // Values after reset
  localparam logic [10:0] CTRL_RESET  = 11'h7ff;
  localparam logic [2:0]  CHAN_RESET  = 3'h0;
  localparam logic [15:0] SEQ_RESET   = 16'h0000;
  localparam logic [3:0]  SLOT_RESET  = 4'hf;

  typedef enum logic [1:0] {PM_INVALID, PM_AUTO, PM_SHUTDOWN, PM_NORMAL} power_mode_t;
  typedef enum {MODE_SINGLE, MODE_CONSEC, MODE_SEQ_REG} seq_mode_t;

  // Next set slot after 'from', wrapping; slot s is word bit 15-s, channel s[2:0]
  function automatic logic [3:0] next_set(input logic [15:0] mask, input logic [3:0] from);
    logic [3:0] pick;
    logic [3:0] idx;
    logic       found;
    pick  = from;
    found = 1'b0;
    for (int i = 1; i <= 16; i++)
    begin
      idx = from + 4'(i);
      if (!found && mask[4'hf - idx])
      begin
        pick  = idx;
        found = 1'b1;
      end
    end
    return pick;
  endfunction : next_set

endpackage : adc_ctrl_pkg

// [shared/seq_link_if.sv]
// Carries frame events and channel choice between the link shifter and the sequencer.
// Both ends run on the falling edge of the serial clock.
interface seq_link_if;
  logic        link_rst;
  logic        frame_start;
  logic        frame_end;
  logic [15:0] word;
  logic [2:0]  next_chan;
  logic [2:0]  conv_chan;
  logic        running;
  logic        seq_pend;

  modport link (output link_rst, frame_start, frame_end, word,
                input  next_chan, conv_chan, running, seq_pend);
  modport seq  (input  link_rst, frame_start, frame_end, word,
                output next_chan, conv_chan, running, seq_pend);
endinterface : seq_link_if

// [core/seq_engine.sv]
// Channel sequencer: single channel, consecutive run, or programmed sequence.
// Runs on the falling serial clock; frame events come from the link shifter.
module seq_engine (
  input wire logic sclk,
  seq_link_if.seq  lnk
);

  adc_ctrl_pkg::seq_mode_t mode_q;
  logic [15:0]             seq_reg_q;
  logic [3:0]              slot_q;
  logic [2:0]              last_q;
  logic [3:0]              slot_adv;
  logic [3:0]              slot_first;
  logic [1:0]              sel;

  assign slot_adv   = adc_ctrl_pkg::next_set(seq_reg_q, slot_q);
  assign slot_first = adc_ctrl_pkg::next_set(lnk.word, adc_ctrl_pkg::SLOT_RESET);
  assign sel        = {lnk.word[adc_ctrl_pkg::POS_SEQ_EN], lnk.word[adc_ctrl_pkg::POS_SEQ_REG]};
  assign lnk.running = (mode_q != adc_ctrl_pkg::MODE_SINGLE);

  always_ff @(negedge sclk)
  begin
    if (lnk.link_rst)
    begin
      mode_q        <= adc_ctrl_pkg::MODE_SINGLE;
      lnk.seq_pend  <= 1'b0;
      lnk.next_chan <= adc_ctrl_pkg::CHAN_RESET;
      lnk.conv_chan <= adc_ctrl_pkg::CHAN_RESET;
      seq_reg_q     <= adc_ctrl_pkg::SEQ_RESET;
      slot_q        <= adc_ctrl_pkg::SLOT_RESET;
      last_q        <= adc_ctrl_pkg::CHAN_RESET;
    end
    else if (lnk.frame_start)
    begin
      lnk.conv_chan <= lnk.next_chan;
      case (mode_q)
        adc_ctrl_pkg::MODE_CONSEC:
          lnk.next_chan <= (lnk.next_chan == last_q) ? 3'h0 : lnk.next_chan + 3'h1;
        adc_ctrl_pkg::MODE_SEQ_REG:
        begin
          slot_q        <= slot_adv;
          lnk.next_chan <= slot_adv[2:0];
        end
        default: lnk.next_chan <= lnk.next_chan;
      endcase
    end
    else if (lnk.frame_end)
    begin
      if (lnk.seq_pend)
      begin
        seq_reg_q    <= lnk.word;
        lnk.seq_pend <= 1'b0;
        if (lnk.word != 16'h0000)
        begin
          mode_q        <= adc_ctrl_pkg::MODE_SEQ_REG;
          slot_q        <= slot_first;
          lnk.next_chan <= slot_first[2:0];
        end
        else
        begin
          mode_q <= adc_ctrl_pkg::MODE_SINGLE;
        end
      end
      else if (lnk.word[adc_ctrl_pkg::POS_WRITE])
      begin
        case (sel)
          2'b01:
          begin
            lnk.seq_pend  <= 1'b1;
            mode_q        <= adc_ctrl_pkg::MODE_SINGLE;
            lnk.next_chan <= lnk.word[adc_ctrl_pkg::POS_ADDR_HI:adc_ctrl_pkg::POS_ADDR_LO];
          end
          2'b10:
          begin
            if (mode_q == adc_ctrl_pkg::MODE_SINGLE)
              lnk.next_chan <= lnk.word[adc_ctrl_pkg::POS_ADDR_HI:adc_ctrl_pkg::POS_ADDR_LO];
          end
          2'b11:
          begin
            mode_q        <= adc_ctrl_pkg::MODE_CONSEC;
            last_q        <= lnk.word[adc_ctrl_pkg::POS_ADDR_HI:adc_ctrl_pkg::POS_ADDR_LO];
            lnk.next_chan <= 3'h0;
          end
          default:
          begin
            mode_q        <= adc_ctrl_pkg::MODE_SINGLE;
            lnk.next_chan <= lnk.word[adc_ctrl_pkg::POS_ADDR_HI:adc_ctrl_pkg::POS_ADDR_LO];
          end
        endcase
      end
    end
  end

endmodule : seq_engine

// [core/adc_ctrl.sv]
// Digital control of an eight-channel serial converter: link shifter, control word,
// result framing and power mode state. Assumes sclk idles high with cs_n high
// between frames, and runs inside frames and while srst is held; clk is free running.
module adc_ctrl (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       din,
  input  wire logic       sar_bit,
  output logic            dout,
  output logic            powered,
  output logic            range_double,
  output logic [2:0]      mux_chan,
  output logic            sample,
  output logic            seq_active
);

  seq_link_if lnk ();

  // Link domain state
  logic        rst_meta_q;
  logic        rst_sync_q;
  logic [4:0]  bit_cnt_q;
  logic [14:0] shift_q;
  logic [10:0] ctrl_q;
  logic        coding_lat_q;
  logic        dout_q;
  logic        start_tgl_q;
  logic        end_tgl_q;
  logic [1:0]  snap_pm_q;
  logic        snap_range_q;
  logic [2:0]  snap_chan_q;
  logic        snap_run_q;
  logic [15:0] word_now;
  logic        in_frame;

  // Core domain state
  logic [2:0]  start_sync_q;
  logic [2:0]  end_sync_q;
  logic        start_evt;
  logic        end_evt;
  logic        powered_q;
  logic        range_q;
  logic [2:0]  chan_q;
  logic        sample_q;
  logic        seq_active_q;
  adc_ctrl_pkg::power_mode_t pm_q;

  seq_engine u_seq (
    .sclk (sclk),
    .lnk  (lnk.seq)
  );

  // Word lands in control only with the write bit set and no sequence load armed
  function automatic logic ctrl_loads(input logic pend, input logic [15:0] w);
    return !pend && w[adc_ctrl_pkg::POS_WRITE];
  endfunction : ctrl_loads

  function automatic logic [1:0] pm_field(input logic [10:0] c);
    return c[adc_ctrl_pkg::POS_PM_HI:adc_ctrl_pkg::POS_PM_LO];
  endfunction : pm_field

  function automatic logic range_field(input logic [10:0] c);
    return c[adc_ctrl_pkg::POS_RANGE];
  endfunction : range_field

  // Reset reaches the link only while the serial clock runs
  always_ff @(negedge sclk)
  begin
    rst_meta_q <= srst;
    rst_sync_q <= rst_meta_q;
  end

  assign lnk.link_rst = rst_sync_q;
  assign in_frame     = (bit_cnt_q != adc_ctrl_pkg::CNT_DONE);
  assign word_now     = {shift_q, din};

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      bit_cnt_q <= 5'h00;
    else if (in_frame)
      bit_cnt_q <= bit_cnt_q + 5'h01;
  end

  always_ff @(negedge sclk)
  begin
    if (!cs_n && in_frame)
      shift_q <= word_now[14:0];
  end

  assign lnk.frame_start = !cs_n && (bit_cnt_q == 5'h00);
  assign lnk.frame_end   = !cs_n && (bit_cnt_q == adc_ctrl_pkg::CNT_LAST);
  assign lnk.word        = word_now;

  // Control word held unless write bit set
  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
      ctrl_q <= adc_ctrl_pkg::CTRL_RESET;
    else if (lnk.frame_end && ctrl_loads(lnk.seq_pend, word_now))
      ctrl_q <= word_now[10:0];
  end

  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
      coding_lat_q <= 1'b1;
    else if (lnk.frame_start)
      coding_lat_q <= ctrl_q[adc_ctrl_pkg::POS_CODING];
  end

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      dout_q <= 1'b0;
    else
    begin
      case (bit_cnt_q)
        5'h00: dout_q <= lnk.next_chan[2];
        5'h01: dout_q <= lnk.conv_chan[1];
        5'h02: dout_q <= lnk.conv_chan[0];
        adc_ctrl_pkg::CNT_DATA0: dout_q <= sar_bit ^ ~coding_lat_q;
        default:
        begin
          if (bit_cnt_q > adc_ctrl_pkg::CNT_DATA0 && bit_cnt_q <= adc_ctrl_pkg::CNT_DATAN)
            dout_q <= sar_bit;
          else
            dout_q <= 1'b0;
        end
      endcase
    end
  end

  assign dout = dout_q;

  // Snapshot is written on the same edge as its toggle and then held for the
  // rest of the frame, so the core may read it once the toggle has crossed.
  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
      start_tgl_q <= 1'b0;
    else if (lnk.frame_start)
      start_tgl_q <= ~start_tgl_q;
  end

  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
    begin
      snap_chan_q <= adc_ctrl_pkg::CHAN_RESET;
      snap_run_q  <= 1'b0;
    end
    else if (lnk.frame_start)
    begin
      snap_chan_q <= lnk.next_chan;
      snap_run_q  <= lnk.running;
    end
  end

  // A cut frame never reaches its last edge, so it raises no end event
  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
      end_tgl_q <= 1'b0;
    else if (lnk.frame_end)
      end_tgl_q <= ~end_tgl_q;
  end

  // Power and range follow the word only when it really lands in control
  always_ff @(negedge sclk)
  begin
    if (rst_sync_q)
    begin
      snap_pm_q    <= 2'b11;
      snap_range_q <= 1'b0;
    end
    else if (lnk.frame_end)
    begin
      if (ctrl_loads(lnk.seq_pend, word_now))
      begin
        snap_pm_q    <= pm_field(word_now[10:0]);
        snap_range_q <= range_field(word_now[10:0]);
      end
      else
      begin
        snap_pm_q    <= pm_field(ctrl_q);
        snap_range_q <= range_field(ctrl_q);
      end
    end
  end

  // Toggle synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk)
  begin
    if (srst)
      start_sync_q <= 3'h0;
    else
      start_sync_q <= {start_sync_q[1:0], start_tgl_q};
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      end_sync_q <= 3'h0;
    else
      end_sync_q <= {end_sync_q[1:0], end_tgl_q};
  end

  assign start_evt = start_sync_q[2] ^ start_sync_q[1];
  assign end_evt   = end_sync_q[2] ^ end_sync_q[1];

  always_ff @(posedge clk)
  begin
    if (srst)
      pm_q <= adc_ctrl_pkg::PM_NORMAL;
    else if (end_evt)
      pm_q <= adc_ctrl_pkg::power_mode_t'(snap_pm_q);
  end

  // Power state; an invalid mode keeps the previous state
  always_ff @(posedge clk)
  begin
    if (srst)
      powered_q <= 1'b1;
    else if (end_evt)
    begin
      case (adc_ctrl_pkg::power_mode_t'(snap_pm_q))
        adc_ctrl_pkg::PM_NORMAL:   powered_q <= 1'b1;
        adc_ctrl_pkg::PM_SHUTDOWN: powered_q <= 1'b0;
        adc_ctrl_pkg::PM_AUTO:     powered_q <= 1'b0;
        default:                   powered_q <= powered_q;
      endcase
    end
    else if (start_evt && pm_q == adc_ctrl_pkg::PM_AUTO)
      powered_q <= 1'b1;
  end

  // Input range select
  // Flop holds the double-range level itself, so the pin needs no gate
  always_ff @(posedge clk)
  begin
    if (srst)
      range_q <= 1'b1;
    else if (end_evt)
      range_q <= ~snap_range_q;
  end

  // Strobe for the converter front end, one core cycle per frame
  always_ff @(posedge clk)
  begin
    if (srst)
      sample_q <= 1'b0;
    else
      sample_q <= start_evt;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      chan_q <= adc_ctrl_pkg::CHAN_RESET;
    else if (start_evt)
      chan_q <= snap_chan_q;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      seq_active_q <= 1'b0;
    else if (start_evt)
      seq_active_q <= snap_run_q;
  end

  assign powered      = powered_q;
  assign range_double = range_q;
  assign mux_chan     = chan_q;
  assign sample       = sample_q;
  assign seq_active   = seq_active_q;

endmodule : adc_ctrl

// [bench/host_model.sv]
// Host serial master model: 16-clock frames, word sent MSB first.
// Serial clock idles high and runs at 12 ns inside frames and during idle() calls.
module host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  output logic      sar_bit,
  input  wire logic dout
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    sclk    = 1'b1;
    cs_n    = 1'b1;
    din     = 1'b0;
    sar_bit = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n)
    begin
      #6 sclk = 1'b0;
      #6 sclk = 1'b1;
    end
  endtask : idle

  task automatic run(input logic [15:0] w, input logic [11:0] s, output logic [15:0] r);
    #1000 cs_n = 1'b0;
    din = w[15];
    #6;
    for (int k = 0; k < 16; k++)
    begin
      r = {r[14:0], dout};
      sclk = 1'b0;
      #6 sclk = 1'b1;
      // Released lines toggle so a stale level never matches by luck
      din = (k < 15) ? w[14 - k] : ~din;
      sar_bit = (k >= 2 && k <= 13) ? s[13 - k] : ~sar_bit;
      #6;
    end
    #54 cs_n = 1'b1;
  endtask : run
endmodule : host_model

// [bench/adc_ctrl_asserts.sv]
// Checker for the converter control top: reset, pulses, serial framing.
// Sees only top ports; the frame edge count lives in helper logic.
module adc_ctrl_asserts (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic       din,
  input wire logic       sar_bit,
  input wire logic       dout,
  input wire logic       powered,
  input wire logic       range_double,
  input wire logic [2:0] mux_chan,
  input wire logic       sample,
  input wire logic       seq_active
);
  logic [4:0] edge_q;
  logic [2:0] addr_q;

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
      edge_q <= 5'h00;
    else if (edge_q != 5'h1f)
      edge_q <= edge_q + 5'h01;
  end

  always_ff @(negedge sclk)
  begin
    if (edge_q >= 5'h01 && edge_q <= 5'h03)
      addr_q <= {addr_q[1:0], dout};
  end

  sequence s_pulse;
    sample ##1 !sample;
  endsequence

  AST_RST_VALUES: assert property (@(posedge clk) srst |=>
    powered && range_double && !sample && !seq_active && mux_chan == 3'h0) else $error("reset values wrong");
  AST_SAMPLE_PULSE: assert property (@(posedge clk) disable iff (srst) sample |-> s_pulse)
    else $error("sample not one cycle");
  AST_SAMPLE_FRAME: assert property (@(posedge clk) disable iff (srst) sample |-> !cs_n)
    else $error("sample outside frame");
  AST_CHAN_FRAME: assert property (@(posedge clk) disable iff (srst) $changed(mux_chan) |-> !cs_n)
    else $error("channel changed outside frame");
  AST_CTRL_FRAME: assert property (@(posedge clk) disable iff (srst)
    $changed(powered) || $changed(range_double) || $changed(seq_active) |-> !cs_n) else $error("state changed idle");
  AST_DOUT_IDLE: assert property (@(posedge clk) disable iff (srst) cs_n || edge_q == 5'h10 |-> !dout)
    else $error("dout not zero");
  AST_DOUT_LEAD: assert property (@(negedge sclk) disable iff (srst) edge_q == 5'h00 |-> !dout)
    else $error("leading bit not zero");
  AST_DOUT_ADDR: assert property (@(negedge sclk) disable iff (srst) edge_q == 5'h08 |-> addr_q == mux_chan)
    else $error("address bits wrong");
  AST_DOUT_DATA: assert property (@(negedge sclk) disable iff (srst)
    edge_q >= 5'h05 && edge_q <= 5'h0f |-> dout == $past(sar_bit)) else $error("data bit wrong");
endmodule : adc_ctrl_asserts

bind adc_ctrl adc_ctrl_asserts i_chk (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din),
  .sar_bit(sar_bit), .dout(dout), .powered(powered), .range_double(range_double), .mux_chan(mux_chan),
  .sample(sample), .seq_active(seq_active));

// [bench/adc_ctrl_test.sv]
// Testbench for the converter control: host frames and a result scoreboard.
// Assumes the host model owns the serial side; core clock 8 ns.
module adc_ctrl_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic        clk, srst, sclk, cs_n, din, sar_bit, dout, powered, range_double, sample, seq_active;
  logic [2:0]  mux_chan, ch, addr, last, pos;
  logic [15:0] exp_q[$];
  logic [15:0] res, mask;
  logic [3:0]  slot;
  logic [1:0]  mode;
  logic        code, arm, hi;
  int          errors, comparisons;
  event        got;

  adc_ctrl i_dut (.clk(clk), .srst(srst), .sclk(sclk), .cs_n(cs_n), .din(din), .sar_bit(sar_bit),
    .dout(dout), .powered(powered), .range_double(range_double), .mux_chan(mux_chan),
    .sample(sample), .seq_active(seq_active));
  host_model i_host (.sclk(sclk), .cs_n(cs_n), .din(din), .sar_bit(sar_bit), .dout(dout));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_of_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  function automatic logic [15:0] ctl(input logic [1:0] sq, input logic [2:0] a, input logic [1:0] pm);
    return {4'h0, 1'b1, sq[1], 1'b0, a, pm, sq[0], 3'h1};
  endfunction : ctl

  // Channel model: 0 single, 1 consecutive, 2 programmed
  task automatic frame(input logic [15:0] w);
    logic [11:0] s;
    s = 12'($urandom);
    ch = addr;
    if (mode == 2'h1)
    begin
      ch = pos;
      pos = (pos == last) ? 3'h0 : pos + 3'h1;
    end
    if (mode == 2'h2)
    begin
      do slot++; while (!mask[4'hf - slot]);
      ch = slot[2:0];
    end
    exp_q.push_back({1'b0, ch, s ^ {~code, 11'h000}});
    fork
      i_host.run(w, s, res);
      begin
        hi = 1'b0;
        repeat (165) @(posedge clk) hi |= powered;
      end
    join
    -> got;
    if (arm)
    begin
      arm = 1'b0;
      mode = (w == 16'h0000) ? 2'h0 : 2'h2;
      mask = w;
      slot = 4'hf;
    end
    else if (w[11])
    begin
      code = w[0];
      case ({w[10], w[3]})
        2'b00: mode = 2'h0;
        2'b01:
        begin
          mode = 2'h0;
          arm = 1'b1;
        end
        2'b11:
        begin
          mode = 2'h1;
          last = w[8:6];
          pos = 3'h0;
        end
        default: ;
      endcase
      if (mode == 2'h0)
        addr = w[8:6];
    end
  endtask : frame

  initial
  begin
    forever
    begin
      @(got);
      chk("result", exp_q.pop_front(), res);
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("[ERR] run expected end seen timeout");
    end_of_test();
  end

  initial
  begin
    srst = 1'b1;
    {errors, comparisons} = '0;
    {mode, addr, pos, last, arm, mask} = '0;
    code = 1'b1;
    slot = 4'hf;
    void'($urandom(38962));
    repeat (2) @(posedge clk);
    // Link reset passes two serial flops before it acts
    i_host.idle(4);
    @(posedge clk) srst <= 1'b0;
    i_host.idle(2);
    chk("powered", 16'(powered), 16'h1);
    chk("range", 16'(range_double), 16'h1);
    $display("test reset done");
    for (int a = 0; a < 8; a++) frame(ctl(2'b00, 3'(a), 2'b11));
    frame(16'($urandom) & 16'hf7ff);
    frame(ctl(2'b00, 3'h5, 2'b11) & 16'hfffe);
    frame(ctl(2'b00, 3'h5, 2'b11) | 16'h0002);
    chk("range", 16'(range_double), 16'h0);
    frame(ctl(2'b11, 3'h2, 2'b11));
    frame(ctl(2'b10, 3'h2, 2'b11));
    chk("seq", 16'(seq_active), 16'h1);
    repeat (4) frame(16'h0000);
    // Exit with write bit set, both sequencer bits clear
    frame(ctl(2'b00, 3'h3, 2'b11));
    frame(16'h0000);
    chk("seq", 16'(seq_active), 16'h0);
    $display("test consecutive done");
    frame(ctl(2'b01, 3'h3, 2'b11));
    frame(16'h5002);
    repeat (5) frame(16'h0000);
    chk("seq", 16'(seq_active), 16'h1);
    frame(ctl(2'b00, 3'h0, 2'b11));
    frame(ctl(2'b01, 3'h1, 2'b11));
    frame(16'h2400);
    repeat (3) frame(16'h0000);
    chk("seq", 16'(seq_active), 16'h1);
    frame(ctl(2'b00, 3'h0, 2'b11));
    $display("test sequence done");
    frame(ctl(2'b00, 3'h0, 2'b10));
    chk("powered", 16'(powered), 16'h0);
    frame(ctl(2'b00, 3'h0, 2'b01));
    chk("wake", 16'(hi), 16'h0);
    frame(16'h0000);
    chk("wake", 16'(hi), 16'h1);
    chk("powered", 16'(powered), 16'h0);
    frame(ctl(2'b00, 3'h0, 2'b11));
    chk("powered", 16'(powered), 16'h1);
    $display("test power done");
    repeat (2) @(posedge clk);
    chk("pending", 16'(exp_q.size()), 16'h0);
    end_of_test();
  end
endmodule : adc_ctrl_test
